/* common/serdes_align_regs.svh */
// Register offsets, field positions, reset values and bit-time counts of the aligner
`ifndef SERDES_ALIGN_REGS_SVH
`define SERDES_ALIGN_REGS_SVH

// ***************************************************************
// Register map (byte addresses on the bus)
// ***************************************************************
`define REG_CTRL_OFS 8'h00
`define REG_STATUS_OFS 8'h04
`define REG_COMMA_CNT_OFS 8'h08

// ***************************************************************
// Control field positions and reset value
// ***************************************************************
`define CTRL_LOOP_BIT 0
`define CTRL_ALIGN_BIT 1
`define CTRL_LOCKREF_BIT 2
`define CTRL_WIDTH 3
`define CTRL_RESET 3'h6

// ***************************************************************
// Word and timing counts, in serial bit times
// ***************************************************************
`define WORD_LAST 4'h9
`define CLK_PHASE_LAST 4'h9
`define SYNC_POINT 4'h3
`define SYNC_HIGH_BITS 3'h5
`define COMMA_WORD 10'h17C

`endif

/* common/serdes_align_pkg.sv */
// Types shared by the serializer, the pin synchroniser and the aligner top
`include "serdes_align_regs.svh"

package serdes_align_pkg;

    // Control bits as stored in the control register
    typedef struct packed {
        logic lockRefN;    // Low forces the receive timing onto the reference
        logic alignEn;     // Comma search and word alignment on
        logic loopback_enable;      // Internal loopback on
    } ctrl_t;

    // One differential serial pin pair
    typedef struct packed {
        logic pos;         // True side
        logic neg;         // Complement side
    } serial_pair_t;

    // Byte clock generator mode
    typedef enum logic {
        CLK_RUN,
        CLK_STRETCH
    } clk_mode_t;

    // True when a ten-bit window holds the alignment character
    function automatic logic is_comma(input logic [9:0] w);
        return w == `COMMA_WORD;
    endfunction

endpackage

/* core/serdes_rx_pin_sync.sv */
// Three-stage synchroniser for the differential serial receive pins
`timescale 1ns/1ps
`default_nettype none

module serdes_rx_pin_sync (
    input wire logic clk_sys,                          // System clock
    input wire logic rst_n,                            // Synchronous reset, active low
    input wire serdes_align_pkg::serial_pair_t pinIn,  // Raw pin pair
    output serdes_align_pkg::serial_pair_t pinOut      // Synchronised pin pair
);

    // ***************************************************************
    // Synchroniser stages
    // ***************************************************************
    serdes_align_pkg::serial_pair_t s1Q, s2Q, s3Q;     // Stage flops
    serdes_align_pkg::serial_pair_t outQ, outD;        // Accepted level

    // Each stage holds one serial bit; an agreement filter would swallow single-bit runs
    always_comb begin
        outD = s3Q;
    end

    // Register the stages; the first is read only by the second
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s1Q <= '{pos: 1'h0, neg: 1'h1};
            s2Q <= '{pos: 1'h0, neg: 1'h1};
            s3Q <= '{pos: 1'h0, neg: 1'h1};
            outQ <= '{pos: 1'h0, neg: 1'h1};
        end else begin
            s1Q <= pinIn;
            s2Q <= s1Q;
            s3Q <= s2Q;
            outQ <= outD;
        end
    end

    assign pinOut = outQ;

endmodule

`default_nettype wire

/* core/serdes_tx_serializer.sv */
// Transmit word register, times-ten bit sequencer and serial line driver
`timescale 1ns/1ps
`default_nettype none
`include "serdes_align_regs.svh"

module serdes_tx_serializer (
    input wire logic clk_sys,                          // System clock, one bit time
    input wire logic rst_n,                            // Synchronous reset, active low
    input wire logic refTick,                          // Reference rising edge, one-cycle
    input wire logic [9:0] txWord,                     // Word to capture
    input wire logic loopback_enable,                           // Loopback holds the line static
    output logic txBit,                                // Current serial bit
    output logic [3:0] bitIdx,                         // Position of current bit in word
    output serdes_align_pkg::serial_pair_t txLine      // Differential line outputs
);

    // ***************************************************************
    // Shift register and bit counter
    // ***************************************************************
    logic [9:0] shiftQ, shiftD;                        // Bits still to send
    logic [3:0] idxQ, idxD;                            // Bit position
    serdes_align_pkg::serial_pair_t lineQ, lineD;      // Registered line levels

    // Capture on the reference edge, then shift one bit per bit time
    always_comb begin
        if (refTick) begin
            shiftD = txWord;
            idxD = 4'h0;
        end else begin
            shiftD = {1'h0, shiftQ[9:1]};
            idxD = (idxQ == `WORD_LAST) ? 4'h0 : idxQ + 4'h1;
        end
        if (loopback_enable) begin
            lineD = '{pos: 1'h0, neg: 1'h1};
        end else begin
            lineD = '{pos: shiftQ[0], neg: ~shiftQ[0]};
        end
    end

    // Register the serializer state
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            shiftQ <= 10'h000;
            idxQ <= 4'h0;
            lineQ <= '{pos: 1'h0, neg: 1'h1};
        end else begin
            shiftQ <= shiftD;
            idxQ <= idxD;
            lineQ <= lineD;
        end
    end

    assign txBit = shiftQ[0];
    assign bitIdx = idxQ;
    assign txLine = lineQ;

endmodule

`default_nettype wire

/* core/gigabit_serdes_comma_align.sv */
// Ten-bit serdes core: comma alignment, byte clocks, sync pulse, loopback, bus registers
// One clk_sys cycle stands for one serial bit time; ten cycles are one word.
`timescale 1ns/1ps
`default_nettype none
`include "serdes_align_regs.svh"

module gigabit_serdes_comma_align (
    input wire logic clk_sys,                          // System clock, 25 MHz
    input wire logic rst_n,                            // Synchronous reset, active low
    input wire logic [7:0] wb_adr_i,                   // Bus byte address
    input wire logic [31:0] wb_dat_i,                  // Bus write data
    input wire logic [3:0] wb_sel_i,                   // Bus byte enables
    input wire logic wb_we_i,                          // Bus write
    input wire logic wb_cyc_i,                         // Bus cycle
    input wire logic wb_stb_i,                         // Bus strobe
    output logic [31:0] wb_dat_o,                      // Bus read data
    output logic wb_ack_o,                             // Bus acknowledge
    input wire logic ref_clock,                        // Reference edge, one-cycle pulse
    input wire logic [9:0] tx_data,                    // Transmit word
    input wire serdes_align_pkg::serial_pair_t serial_rx, // Receive pin pair
    output serdes_align_pkg::serial_pair_t serial_tx,  // Transmit pin pair
    output logic [9:0] rx_data,                        // Received word
    output logic rx_byte_clock_a,                      // Odd byte clock
    output logic rx_byte_clock_b,                      // Even byte clock
    output logic comma_detect                          // Comma found pulse
);

    // ***************************************************************
    // Transmit path and pin synchroniser
    // ***************************************************************
    serdes_align_pkg::ctrl_t ctrlQ, ctrlD;             // Control register
    serdes_align_pkg::serial_pair_t rxPins;            // Synchronised receive pins
    logic txBit;                                       // Bit being sent
    logic [3:0] txIdx;                                 // Transmit bit position

    serdes_tx_serializer serdes_tx_serializer_inst (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .refTick(ref_clock),
        .txWord(tx_data),
        .loopback_enable(ctrlQ.loopback_enable),
        .txBit(txBit),
        .bitIdx(txIdx),
        .txLine(serial_tx)
    );

    serdes_rx_pin_sync serdes_rx_pin_sync_inst (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .pinIn(serial_rx),
        .pinOut(rxPins)
    );

    // ***************************************************************
    // Receive word assembly and alignment
    // ***************************************************************
    logic rxBit;                                       // Bit entering the receiver
    logic [9:0] winQ, winD;                            // Last ten bits, earliest at 0
    logic [3:0] rxPosQ, rxPosD;                        // Bit position in word
    logic [3:0] posNext;                               // Free-running next position
    logic parityQ, parityD;                            // Presented word is byte 1 or 3
    logic [9:0] rxDataQ, rxDataD;                      // Presented word
    logic matchNow;                                    // Comma seen in window
    logic wordDone;                                    // Window taken as a word
    logic adjust;                                      // Clock phase must move

    // Source select, comma search and word boundary
    always_comb begin
        if (ctrlQ.loopback_enable) begin
            rxBit = txBit;
        end else begin
            rxBit = rxPins.pos & ~rxPins.neg;
        end
        winD = {rxBit, winQ[9:1]};
        posNext = (rxPosQ == `WORD_LAST) ? 4'h0 : rxPosQ + 4'h1;
        matchNow = ctrlQ.alignEn && ctrlQ.lockRefN
            && serdes_align_pkg::is_comma(winQ);
        wordDone = (rxPosQ == `WORD_LAST) || matchNow;
        rxDataD = wordDone ? winQ : rxDataQ;
        rxPosD = wordDone ? 4'h0 : posNext;
        parityD = wordDone ? ~parityQ : parityQ;
        adjust = 1'h0;
        if (matchNow) begin
            parityD = 1'h0;
            adjust = (rxPosQ != `WORD_LAST) || !parityQ;
        end
        if (!ctrlQ.lockRefN) begin
            rxPosD = txIdx;
            adjust = (txIdx != posNext);
        end
    end

    // Register the receive word state
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            winQ <= 10'h000;
            rxPosQ <= 4'h0;
            parityQ <= 1'h1;
            rxDataQ <= 10'h000;
        end else begin
            winQ <= winD;
            rxPosQ <= rxPosD;
            parityQ <= parityD;
            rxDataQ <= rxDataD;
        end
    end

    // ***************************************************************
    // Byte clock generator
    // ***************************************************************
    serdes_align_pkg::clk_mode_t modeQ, modeD;         // Running or stretching
    logic clkBQ, clkBD;                                // Even byte clock level
    logic [3:0] halfCntQ, halfCntD;                    // Cycles in current phase
    logic syncPoint;                                   // Place for an even-clock rise

    // Phases are ten bit times; a stretch only holds a level longer
    always_comb begin
        syncPoint = !parityQ && (rxPosQ == `SYNC_POINT);
        modeD = modeQ;
        clkBD = clkBQ;
        halfCntD = (halfCntQ == `CLK_PHASE_LAST) ? halfCntQ : halfCntQ + 4'h1;
        case (modeQ)
            serdes_align_pkg::CLK_RUN: begin
                if (halfCntQ == `CLK_PHASE_LAST) begin
                    clkBD = ~clkBQ;
                    halfCntD = 4'h0;
                end
            end
            serdes_align_pkg::CLK_STRETCH: begin
                if (halfCntQ == `CLK_PHASE_LAST) begin
                    if (clkBQ) begin
                        clkBD = 1'h0;
                        halfCntD = 4'h0;
                    end else if (syncPoint) begin
                        clkBD = 1'h1;
                        halfCntD = 4'h0;
                        modeD = serdes_align_pkg::CLK_RUN;
                    end
                end
            end
            default: begin
                modeD = serdes_align_pkg::CLK_STRETCH;
            end
        endcase
        if (adjust) begin
            modeD = serdes_align_pkg::CLK_STRETCH;
        end
    end

    // Register the clock generator
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            modeQ <= serdes_align_pkg::CLK_STRETCH;
            clkBQ <= 1'h0;
            halfCntQ <= 4'h0;
        end else begin
            modeQ <= modeD;
            clkBQ <= clkBD;
            halfCntQ <= halfCntD;
        end
    end

    // ***************************************************************
    // Comma detect pulse
    // ***************************************************************
    logic pendQ, pendD;                                // Comma word awaits its clock
    logic [2:0] syncCntQ, syncCntD;                    // Pulse cycles left
    logic [15:0] commaCntQ, commaCntD;                 // Pulses emitted
    logic pulseStart;                                  // Pulse begins now

    // The pulse starts with the even clock rise of the comma word
    always_comb begin
        pulseStart = pendQ && clkBD && !clkBQ;
        pendD = pendQ;
        if (pulseStart || wordDone) begin
            pendD = 1'h0;
        end
        if (wordDone && matchNow) begin
            pendD = 1'h1;
        end
        syncCntD = (syncCntQ != 3'h0) ? syncCntQ - 3'h1 : 3'h0;
        commaCntD = commaCntQ;
        if (pulseStart) begin
            syncCntD = `SYNC_HIGH_BITS;
            commaCntD = commaCntQ + 16'h0001;
        end
        if (!ctrlQ.alignEn) begin
            pendD = 1'h0;
            syncCntD = 3'h0;
        end
    end

    // Register the pulse state
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pendQ <= 1'h0;
            syncCntQ <= 3'h0;
            commaCntQ <= 16'h0000;
        end else begin
            pendQ <= pendD;
            syncCntQ <= syncCntD;
            commaCntQ <= commaCntD;
        end
    end

    // ***************************************************************
    // Bus slave
    // ***************************************************************
    logic ackQ, ackD;                                  // Acknowledge
    logic [31:0] rdQ, rdD;                             // Read data
    logic reqNew;                                      // Fresh request

    // Answer one cycle after the request; a write lands on the ack edge
    always_comb begin
        reqNew = wb_cyc_i && wb_stb_i && !ackQ;
        ackD = reqNew;
        rdD = rdQ;
        ctrlD = ctrlQ;
        if (reqNew) begin
            case (wb_adr_i)
                `REG_CTRL_OFS: rdD = {29'h0, ctrlQ};
                `REG_STATUS_OFS: rdD = {24'h0, comma_detect, modeQ, parityQ, 1'h0, rxPosQ};
                `REG_COMMA_CNT_OFS: rdD = {16'h0000, commaCntQ};
                default: rdD = 32'h0000_0000;
            endcase
        end
        if (wb_cyc_i && wb_stb_i && ackQ && wb_we_i && wb_sel_i[0]
            && wb_adr_i == `REG_CTRL_OFS) begin
            ctrlD = wb_dat_i[`CTRL_WIDTH-1:0];
        end
    end

    // Register the bus state
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ackQ <= 1'h0;
            rdQ <= 32'h0000_0000;
            ctrlQ <= `CTRL_RESET;
        end else begin
            ackQ <= ackD;
            rdQ <= rdD;
            ctrlQ <= ctrlD;
        end
    end

    // ***************************************************************
    // Outputs
    // ***************************************************************
    assign wb_ack_o = ackQ;
    assign wb_dat_o = rdQ;
    assign rx_data = rxDataQ;
    assign rx_byte_clock_b = clkBQ;
    assign rx_byte_clock_a = ~clkBQ;
    assign comma_detect = (syncCntQ != 3'h0);

    // ***************************************************************
    // Checks
    // ***************************************************************
    logic [3:0] phaseLenQ;                             // Cycles since clock b changed

    always_ff @(posedge clk_sys) begin
        if (!rst_n || (clkBD != clkBQ)) begin
            phaseLenQ <= 4'h0;
        end else if (phaseLenQ != 4'hF) begin
            phaseLenQ <= phaseLenQ + 4'h1;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    tx_static_a: assert property (ctrlQ.loopback_enable && $past(ctrlQ.loopback_enable) |->
        serial_tx.pos == 1'h0 && serial_tx.neg == 1'h1) else $error("tx not static");
    tx_drive_a: assert property (!ctrlQ.loopback_enable |=> serial_tx.pos != serial_tx.neg)
        else $error("tx pair not differential");
    loop_route_a: assert property (ctrlQ.loopback_enable |=> winQ[9] == $past(txBit))
        else $error("loopback not routed");
    sync_len_a: assert property (disable iff (!rst_n || !ctrlQ.alignEn)
        $rose(comma_detect) |-> comma_detect [*5] ##1 !comma_detect)
        else $error("sync pulse length");
    sync_gate_a: assert property (!ctrlQ.alignEn |=> !comma_detect)
        else $error("sync while align off");
    sync_clock_a: assert property ($rose(comma_detect) |-> $rose(rx_byte_clock_b))
        else $error("sync not on clock b rise");
    sync_data_a: assert property (comma_detect |-> rx_data == `COMMA_WORD)
        else $error("sync without comma word");
    clk_anti_a: assert property (rx_byte_clock_a != rx_byte_clock_b)
        else $error("byte clocks not inverted");
    clk_phase_a: assert property ((rx_byte_clock_b != $past(rx_byte_clock_b)) |->
        $past(phaseLenQ) >= 4'h9) else $error("byte clock phase truncated");
    no_align_a: assert property (!ctrlQ.alignEn && ctrlQ.lockRefN |=>
        rxPosQ == (($past(rxPosQ) == `WORD_LAST) ? 4'h0 : $past(rxPosQ) + 4'h1))
        else $error("realign while align off");
    lock_ref_a: assert property (!ctrlQ.lockRefN |=> rxPosQ == $past(txIdx))
        else $error("not locked to reference");

    realign_c: cover property (matchNow && rxPosQ != `WORD_LAST);
    sync_c: cover property ($rose(comma_detect));
    stretch_c: cover property (modeQ == serdes_align_pkg::CLK_STRETCH && clkBQ);
    loop_c: cover property (ctrlQ.loopback_enable && wordDone);

endmodule

`default_nettype wire

/* test/serdes_link_partner.sv */
// Far-side model: reference tick, transmit words and the serial line
`timescale 1ns/1ps
`default_nettype none
`include "serdes_align_regs.svh"

module serdes_link_partner #(
    parameter logic [9:0] DATA_WORD = 10'h2A5           // Filler word between commas
) (
    input wire logic clk_sys,                           // System clock
    input wire logic rst_n,                             // Reset, active low
    input wire serdes_align_pkg::serial_pair_t lineIn,  // Device transmit pair
    output logic refTick,                               // Reference pulse
    output logic [9:0] txWord,                          // Word offered
    output serdes_align_pkg::serial_pair_t lineOut      // Device receive pair
);
    logic [3:0] phase_q;  // Bit time within the word
    logic odd_q;          // Alternates comma and filler

    // Tick every ten bit times; word updated with the tick and held until the next one
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            phase_q <= 4'h0;
            odd_q <= 1'b0;
            refTick <= 1'b0;
            txWord <= 10'h000;
            lineOut <= 2'b01;
        end else begin
            phase_q <= (phase_q == 4'h9) ? 4'h0 : phase_q + 4'h1;
            refTick <= (phase_q == 4'h9);
            if (phase_q == 4'h9) begin
                odd_q <= ~odd_q;
                txWord <= odd_q ? DATA_WORD : `COMMA_WORD;
            end
            lineOut <= lineIn;  // Cable carries the stream back
        end
    end
endmodule
`default_nettype wire

/* test/gigabit_serdes_comma_align_tb.sv */
// Self-checking bench: bus, transmit, loopback, alignment and pulse gating
`timescale 1ns/1ps
`default_nettype none

module gigabit_serdes_comma_align_tb;
    // ****************
    // Signals
    // ****************
    logic clk_sys = 1'b0;  // Bit-time clock
    logic rst_n = 1'b0;  // Reset, active low
    logic [7:0] wb_adr_i = 8'h00;  // Bus address
    logic [31:0] wb_dat_i = 32'h0;  // Bus write data
    logic [3:0] wb_sel_i = 4'h0;  // Bus byte enables
    logic wb_we_i = 1'b0;  // Bus write
    logic wb_cyc_i = 1'b0;  // Bus cycle
    logic wb_stb_i = 1'b0;  // Bus strobe
    logic [31:0] wb_dat_o;  // Bus read data
    logic wb_ack_o;  // Bus acknowledge
    logic refClock;  // Reference pulse
    logic [9:0] txData;  // Transmit word
    serdes_align_pkg::serial_pair_t serialTx;  // Transmit pair
    serdes_align_pkg::serial_pair_t serialRx;  // Receive pair
    logic [9:0] rxData;  // Received word
    logic byteClkA;  // Odd byte clock
    logic byteClkB;  // Even byte clock
    logic commaDetect;  // Comma pulse
    int errors = 0;  // Mismatches
    int cmp_count = 0;  // Comparisons

    always #20 clk_sys = ~clk_sys;

    gigabit_serdes_comma_align gigabit_serdes_comma_align_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .ref_clock(refClock), .tx_data(txData), .serial_rx(serialRx), .serial_tx(serialTx),
        .rx_data(rxData), .rx_byte_clock_a(byteClkA), .rx_byte_clock_b(byteClkB),
        .comma_detect(commaDetect));

    serdes_link_partner serdes_link_partner_inst (.clk_sys(clk_sys), .rst_n(rst_n),
        .lineIn(serialTx), .refTick(refClock), .txWord(txData), .lineOut(serialRx));

    // ****************
    // Tasks
    // ****************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("Comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Classic single cycle, held until ack is sampled
    task automatic bus(input logic [7:0] adr, input logic we, input logic [31:0] dat,
                       input logic [31:0] exp, input string what);
        int n;
        n = 0;
        wb_adr_i <= adr;
        wb_we_i <= we;
        wb_dat_i <= dat;
        wb_sel_i <= 4'hF;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            errors++;
            results();
        end
        if (!we) begin
            check(what, wb_dat_o, exp);
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        @(posedge clk_sys);
    endtask

    // Waits for a pulse, then checks word, clocks and pulse width
    task automatic lock_check();
        int n;
        int hi;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (commaDetect !== 1'b1 && n < 400);
        if (n >= 400) begin
            errors++;
            results();
        end
        check("comma word", rxData, 32'h17C);
        check("clock b at pulse", byteClkB, 32'h1);
        check("clock a at pulse", byteClkA, 32'h0);
        hi = 0;
        repeat (10) begin
            if (commaDetect === 1'b1) begin
                hi++;
            end
            @(posedge clk_sys);
        end
        check("pulse width", 32'(hi), 32'h5);
        check("odd word", rxData, 32'h2A5);
        check("clock a odd", byteClkA, 32'h1);
        check("clock b odd", byteClkB, 32'h0);
        repeat (10) @(posedge clk_sys);
        check("clock b period", byteClkB, 32'h1);
        check("next pulse", commaDetect, 32'h1);
    endtask

    // No pulse may appear under the given control value
    task automatic quiet(input logic [31:0] ctrl);
        int hi;
        bus(8'h00, 1'b1, ctrl, 32'h0, "ctrl");
        repeat (20) @(posedge clk_sys);
        hi = 0;
        repeat (100) begin
            @(posedge clk_sys);
            if (commaDetect === 1'b1) begin
                hi++;
            end
        end
        check("pulses", 32'(hi), 32'h0);
    endtask

    // ****************
    // Main sequence
    // ****************
    initial begin
        int n;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        check("tx idle", serialTx, 32'h1);
        bus(8'h00, 1'b0, 32'h0, 32'h6, "ctrl reset");
        bus(8'h08, 1'b0, 32'h0, 32'h0, "pulse count reset");
        bus(8'h0C, 1'b1, 32'hFF, 32'h0, "unmapped");
        bus(8'h0C, 1'b0, 32'h0, 32'h0, "unmapped");
        bus(8'h00, 1'b0, 32'h0, 32'h6, "ctrl kept");
        $display("test registers done");
        // The partner alternates comma and filler words; wait for a comma offer
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (!(refClock === 1'b1 && txData === 10'h17C) && n < 100);
        if (n >= 100) begin
            errors++;
            results();
        end
        check("offered", txData, 32'h17C);
        @(posedge clk_sys);
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_sys);
            check("tx pos", serialTx.pos, 32'(10'h17C >> i) & 32'h1);
            check("tx neg", serialTx.neg, ~(32'(10'h17C >> i)) & 32'h1);
        end
        $display("test transmit done");
        lock_check();
        $display("test line receive done");
        bus(8'h00, 1'b1, 32'h7, 32'h0, "ctrl");
        repeat (20) begin
            @(posedge clk_sys);
            check("tx static", serialTx, 32'h1);
        end
        lock_check();
        $display("test loopback done");
        quiet(32'h5);
        quiet(32'h3);
        $display("test gating done");
        results();
    end
endmodule
`default_nettype wire
